// ---- core/lpc_cfg.svh ----
/*
  Constants for the LCD power, clock and mode control block: register
  offsets, command patterns, field positions, reset values and timing.
  Assumes it is included by its bare name from core/ sources.
*/
`ifndef LPC_CFG_SVH
`define LPC_CFG_SVH

// ==========================================================
// apb register offsets (byte addresses)
`define LPC_REG_CMD 8'h00
`define LPC_REG_MODE 8'h04
`define LPC_REG_STATUS 8'h08

// ==========================================================
// command patterns
`define LPC_PAT_MODE 4'h5
`define LPC_PAT_OSC 5'h03
`define LPC_PAT_STAT_LO 5'h0C
`define LPC_PAT_STAT_HI 5'h0D

// ==========================================================
// field positions inside the command byte
`define LPC_BIT_INVERT 2
`define LPC_BIT_SLEEP 1
`define LPC_BIT_DISP 0
`define LPC_BIT_RATE 2
`define LPC_BIT_CLKOUT 1
`define LPC_BIT_SRC 0

// ==========================================================
// reset values
`define LPC_RST_INVERT 1'b0
`define LPC_RST_SLEEP 1'b0
`define LPC_RST_DISP 1'b0
`define LPC_RST_RATE 1'b0
`define LPC_RST_CLKOUT 1'b0
`define LPC_RST_SRC 1'b0
`define LPC_RST_STATIC 6'h00

// ==========================================================
// timing: system clock, internal oscillator, pin prescaler
`define LPC_CLK_HZ 200000000
`define LPC_OSC_HZ 230000
// longest half period rounds down
`define LPC_OSC_HALF (`LPC_CLK_HZ / (2 * `LPC_OSC_HZ))
// pin clock is the oscillator divided by q = 24
`define LPC_PIN_DIV 24

`endif

// ---- core/lpc_cmd_decode.sv ----
/*
  Command byte classifier: tells which control command a byte is.
  Assumes a complete byte is presented; purely combinational.
*/
`timescale 1ns/1ps
`include "lpc_cfg.svh"

module lpc_cmd_decode
  import lpc_pkg::*;
(
  // command byte in
  input wire logic [7:0] cmdByte,
  // decoded kind out
  output lpc_pkg::lpc_cmd_t cmdKind
);

  // ==========================================================
  // fixed upper patterns select the command
  always_comb
  begin
    if (cmdByte[7:4] == `LPC_PAT_MODE)
      cmdKind = LPC_CMD_MODE;
    else if (cmdByte[7:3] == `LPC_PAT_OSC)
      cmdKind = LPC_CMD_OSC;
    else if (cmdByte[7:3] == `LPC_PAT_STAT_LO)
      cmdKind = LPC_CMD_STAT_LO;
    else if (cmdByte[7:3] == `LPC_PAT_STAT_HI)
      cmdKind = LPC_CMD_STAT_HI;
    else
      cmdKind = LPC_CMD_NONE;
  end

endmodule

// ---- core/lpc_mode_ctrl.sv ----
/*
  LCD power, clock and mode control, top level. Holds the mode,
  oscillator and static-level settings written as command bytes over
  APB, runs the internal oscillator, selects the timing source, drives
  the shared clock pin and gates LCD and general-purpose outputs.
  Assumes clk at 200 MHz, synchronous active-low resetn, and that the
  shared pin input and strobes are synchronous to clk.
*/
// Local design decisions: the register offsets and the APB interface to the registers.
// Contract
// - line mode cancels DC per line; frame mode over two frames
// - inversion select 0 line inversion (default), 1 frame inversion
// - sleep stops the internal oscillator
// - in sleep PWM channels drive their static level; static stays
// - sleep bit 1 of mode command ties LCD outputs low, stops oscillator
// - display off drives every backplane and segment low
// - display on bit has no effect on general-purpose outputs
// - display on change applies at once, no frame sync
// - oscillator command matches upper five bits fixed pattern
// - rate select 0 means 9.6 kHz external, 1 means 230 kHz
// - clock out enable 0 tristates pin, 1 outputs internal clock
// - source select 0 internal, 1 pin becomes external clock input
// - rate ignored on internal, clock out ignored on external
// - pin carries prescaled clock, static high during sleep
// - external input in sleep may be low, high or floating
// - internal oscillator nominal 230 kHz times LCD and PWM
// - PWM with 9.6 kHz external starts internal oscillator for PWM
`timescale 1ns/1ps
`include "lpc_cfg.svh"

module lpc_mode_ctrl
  import lpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shared clock pin
  input wire logic sharedClockPinIn,
  output logic sharedClockPinOut,
  output logic sharedClockPinOe,
  // from pwm and waveform logic
  input wire logic pwmEnable,
  input wire logic [11:0] chanMode,
  input wire logic [5:0] pwmLevel,
  input wire logic lineStrobe,
  input wire logic frameStrobe,
  // timing and drive outputs
  output logic oscRunning,
  output logic lcdClkTick,
  output logic pwmClkTick,
  output logic lcdDriveEnable,
  output logic drivePolarity,
  output logic [5:0] gpOut
);

  import lpc_pkg::*;

  // ==========================================================
  // settings
  logic inversionSelect;
  logic sleepSelect;
  logic displayOn;
  logic extRateSelect;
  logic clockOutEnable;
  logic clockSourceSelect;
  logic [5:0] staticLevel;
  logic [7:0] lastCmd;

  // ==========================================================
  // bus decode
  logic busAccess;
  logic busTaken;
  logic addrHit;
  logic cmdWrite;
  lpc_cmd_t cmdKind;
  logic [7:0] cmdByte;

  assign busAccess = psel && penable;
  // the access completes at the edge where our pready is high
  assign busTaken = busAccess && pready;
  assign addrHit = (paddr == `LPC_REG_CMD) || (paddr == `LPC_REG_MODE) ||
                   (paddr == `LPC_REG_STATUS);
  assign cmdWrite = busTaken && pwrite && (paddr == `LPC_REG_CMD);
  assign cmdByte = pwdata[7:0];

  lpc_cmd_decode u_decode
  (
    .cmdByte(cmdByte),
    .cmdKind(cmdKind)
  );

  // one wait state on every access keeps pready a plain flop
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= busAccess && !pready;
      pslverr <= busAccess && !pready && !addrHit;
    end
  end

  // ==========================================================
  // command latch: only a full byte written is acted on
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      inversionSelect <= `LPC_RST_INVERT;
      sleepSelect <= `LPC_RST_SLEEP;
      displayOn <= `LPC_RST_DISP;
      extRateSelect <= `LPC_RST_RATE;
      clockOutEnable <= `LPC_RST_CLKOUT;
      clockSourceSelect <= `LPC_RST_SRC;
      staticLevel <= `LPC_RST_STATIC;
      lastCmd <= 8'h00;
    end
    else if (cmdWrite)
    begin
      lastCmd <= cmdByte;
      unique case (cmdKind)
        LPC_CMD_MODE:
        begin
          inversionSelect <= cmdByte[`LPC_BIT_INVERT];
          sleepSelect <= cmdByte[`LPC_BIT_SLEEP];
          displayOn <= cmdByte[`LPC_BIT_DISP];
        end
        LPC_CMD_OSC:
        begin
          extRateSelect <= cmdByte[`LPC_BIT_RATE];
          clockOutEnable <= cmdByte[`LPC_BIT_CLKOUT];
          clockSourceSelect <= cmdByte[`LPC_BIT_SRC];
        end
        LPC_CMD_STAT_LO:
          staticLevel[2:0] <= cmdByte[2:0];
        LPC_CMD_STAT_HI:
          staticLevel[5:3] <= cmdByte[2:0];
        LPC_CMD_NONE:
          staticLevel <= staticLevel;
      endcase
    end
  end

  // ==========================================================
  // read data, taken by the master on the completing edge
  always_ff @(posedge clk)
  begin
    if (!resetn)
      prdata <= 32'h00000000;
    else if (busAccess && !pready && !pwrite)
    begin
      if (paddr == `LPC_REG_CMD)
        prdata <= {24'h000000, lastCmd};
      else if (paddr == `LPC_REG_MODE)
        prdata <= {18'h00000, staticLevel, 2'h0, clockSourceSelect,
                   clockOutEnable, extRateSelect, inversionSelect,
                   sleepSelect, displayOn};
      else if (paddr == `LPC_REG_STATUS)
        prdata <= {27'h0000000, drivePolarity, lcdDriveEnable,
                   sharedClockPinOe, sharedClockPinOut, oscRunning};
      else
        prdata <= 32'h00000000;
    end
  end

  // ==========================================================
  // oscillator enable: off in sleep, on for internal source, and
  // forced on for pwm when the external clock is the slow one
  logic oscRun;
  logic oscTick;
  logic pinClk;

  assign oscRun = !sleepSelect &&
                  (!clockSourceSelect ||
                   (pwmEnable && !extRateSelect));

  lpc_osc_gen u_osc
  (
    .clk(clk),
    .resetn(resetn),
    .run(oscRun),
    .oscTick(oscTick),
    .pinClk(pinClk)
  );

  // ==========================================================
  // source select; pin edges are used only when awake, so a stuck
  // or floating input in sleep cannot produce ticks
  logic extPrev;
  logic extRise;
  logic srcTick;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      extPrev <= 1'b0;
    else
      extPrev <= sharedClockPinIn;
  end

  assign extRise = sharedClockPinIn && !extPrev;
  assign srcTick = clockSourceSelect ?
                   (extRise && !sleepSelect) : oscTick;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      oscRunning <= 1'b0;
      lcdClkTick <= 1'b0;
      pwmClkTick <= 1'b0;
    end
    else
    begin
      oscRunning <= oscRun;
      lcdClkTick <= srcTick;
      // pwm needs the fast clock; slow external hands it the oscillator
      pwmClkTick <= (clockSourceSelect && !extRateSelect) ?
                    oscTick : srcTick;
    end
  end

  // ==========================================================
  // shared clock pin: output only on internal source with enable
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sharedClockPinOe <= 1'b0;
      sharedClockPinOut <= 1'b0;
    end
    else
    begin
      sharedClockPinOe <= clockOutEnable && !clockSourceSelect;
      sharedClockPinOut <= sleepSelect ? 1'b1 : pinClk;
    end
  end

  // ==========================================================
  // lcd gating and dc compensation polarity; display on is applied
  // at once, so flashing it can leave dc on the glass
  always_ff @(posedge clk)
  begin
    if (!resetn)
      lcdDriveEnable <= 1'b0;
    else
      lcdDriveEnable <= displayOn && !sleepSelect;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      drivePolarity <= 1'b0;
    else if (inversionSelect ? frameStrobe : lineStrobe)
      drivePolarity <= ~drivePolarity;
  end

  // ==========================================================
  // general-purpose outputs, independent of display on
  for (genvar ch = 0; ch < 6; ch++)
  begin : g_chan
    lpc_chmode_t mode;
    assign mode = lpc_chmode_t'(chanMode[2*ch +: 2]);
    always_ff @(posedge clk)
    begin
      if (!resetn)
        gpOut[ch] <= 1'b0;
      else if (mode == LPC_CH_STATIC)
        gpOut[ch] <= staticLevel[ch];
      else if (mode == LPC_CH_PWM)
        gpOut[ch] <= sleepSelect ? staticLevel[ch] : pwmLevel[ch];
      else
        gpOut[ch] <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  a_sleep_osc_off: assert property (@(posedge clk) disable iff (!resetn)
    sleepSelect |=> !oscRunning)
    else $error("oscillator running in sleep");

  a_display_gate: assert property (@(posedge clk) disable iff (!resetn)
    !displayOn || sleepSelect |=> !lcdDriveEnable)
    else $error("lcd outputs driven while off or asleep");

  a_sleep_pwm_static: assert property (@(posedge clk)
    disable iff (!resetn)
    sleepSelect && chanMode[3:2] == 2'h3 |=>
    gpOut[1] == $past(staticLevel[1]))
    else $error("pwm channel not static in sleep");

  a_osc_cmd_apply: assert property (@(posedge clk) disable iff (!resetn)
    cmdWrite && cmdByte[7:3] == 5'h03 |=>
    clockSourceSelect == $past(cmdByte[0]) &&
    extRateSelect == $past(cmdByte[2]))
    else $error("oscillator command not applied next cycle");

  a_pin_sleep_high: assert property (@(posedge clk) disable iff (!resetn)
    sleepSelect && clockOutEnable && !clockSourceSelect |=>
    sharedClockPinOut && sharedClockPinOe)
    else $error("shared pin not static high in sleep");

  a_pin_ext_input: assert property (@(posedge clk) disable iff (!resetn)
    clockSourceSelect |=> !sharedClockPinOe)
    else $error("shared pin driven with external source");

  a_auto_osc_pwm: assert property (@(posedge clk) disable iff (!resetn)
    !sleepSelect && clockSourceSelect && !extRateSelect && pwmEnable
    |=> oscRunning)
    else $error("oscillator not started for pwm");

  a_ext_sleep_quiet: assert property (@(posedge clk) disable iff (!resetn)
    sleepSelect && clockSourceSelect |=> !lcdClkTick)
    else $error("external pin ticks in sleep");

  a_frame_polarity: assert property (@(posedge clk) disable iff (!resetn)
    inversionSelect && !frameStrobe |=> $stable(drivePolarity))
    else $error("polarity changed within a frame");

endmodule

// ---- core/lpc_osc_gen.sv ----
/*
  Internal oscillator model: a divider of the system clock that gives
  one tick per nominal oscillator period and a prescaled pin clock.
  Assumes clk at 200 MHz; run low stops and clears everything.
*/
`timescale 1ns/1ps
`include "lpc_cfg.svh"

module lpc_osc_gen
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic run,
  // outputs
  output logic oscTick,
  output logic pinClk
);

  localparam int HALF = `LPC_OSC_HALF;
  localparam int PERIOD = 2 * HALF;
  localparam int PIN_HALF = `LPC_PIN_DIV / 2;

  logic [10:0] divCnt;
  logic [4:0] preCnt;

  // ==========================================================
  // period divider: a tick every full oscillator period
  always_ff @(posedge clk)
  begin
    if (!resetn || !run)
    begin
      divCnt <= 11'h000;
      oscTick <= 1'b0;
    end
    else if (divCnt == 11'(PERIOD - 1))
    begin
      divCnt <= 11'h000;
      oscTick <= 1'b1;
    end
    else
    begin
      divCnt <= divCnt + 11'h001;
      oscTick <= 1'b0;
    end
  end

  // ==========================================================
  // prescaler: pin clock toggles every twelve periods (/24)
  always_ff @(posedge clk)
  begin
    if (!resetn || !run)
    begin
      preCnt <= 5'h00;
      pinClk <= 1'b0;
    end
    else if (oscTick)
    begin
      if (preCnt == 5'(PIN_HALF - 1))
      begin
        preCnt <= 5'h00;
        pinClk <= ~pinClk;
      end
      else
        preCnt <= preCnt + 5'h01;
    end
  end

  a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
    run && oscTick |=> !oscTick [*8])
    else $error("oscillator ticks too close together");

endmodule

// ---- core/lpc_pkg.sv ----
/*
  Types shared by the LCD power, clock and mode control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lpc_pkg;

  // ==========================================================
  // decoded command kinds
  typedef enum {
    LPC_CMD_NONE,
    LPC_CMD_MODE,
    LPC_CMD_OSC,
    LPC_CMD_STAT_LO,
    LPC_CMD_STAT_HI
  } lpc_cmd_t;

  // ==========================================================
  // per-channel output mode, encoding fixed by the command set
  typedef enum logic [1:0] {
    LPC_CH_LCD0 = 2'h0,
    LPC_CH_LCD1 = 2'h1,
    LPC_CH_STATIC = 2'h2,
    LPC_CH_PWM = 2'h3
  } lpc_chmode_t;

endpackage

// ---- testbench/lpc_pin_partner.sv ----
/*
  Far side of the shared clock pin: an external clock source.
  Assumes the bench clock and that the bench says when it runs.
*/
`timescale 1ns/1ps

module lpc_pin_partner
(
  // system clock
  input wire logic clk,
  // design side of the pin
  input wire logic pinOe,
  input wire logic pinOut,
  // bench control
  input wire logic runClk,
  // resolved pin level
  output logic pinLevel
);
  logic extClk = 1'b0;
  logic [1:0] divCnt = 2'h0;

  // ==========================================================
  // source clock
  // running: period of eight cycles; stopped: the line is left floating,
  // so it alternates each cycle rather than holding a stale level
  always_ff @(posedge clk)
  begin
    divCnt <= divCnt + 2'h1;
    if (!runClk || divCnt == 2'h3)
      extClk <= !extClk;
  end

  // the design wins the wire whenever it enables its driver
  assign pinLevel = pinOe ? pinOut : extClk;
endmodule

// ---- testbench/test_lpc_mode_ctrl.sv ----
/*
  Self-checking bench for lpc_mode_ctrl: command writes over APB,
  display gating, inversion, sleep and clock source selection.
  Assumes the pin partner model and a 200 MHz clock.
*/
`timescale 1ns/1ps

module test_lpc_mode_ctrl;
  logic clk = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic pinOut, pinOe, pinLevel, runClk, errVal;
  logic pwmEnable, lineStrobe, frameStrobe;
  logic [11:0] chanMode;
  logic [5:0] pwmLevel, gpOut;
  logic oscRunning, lcdClkTick, pwmClkTick, lcdDriveEnable, drivePolarity;
  int bad_count = 0;
  int comparisons = 0;
  int ticks;
  int pwmTicks;

  // ==========================================================
  // clock, design and pin partner
  always #2.5 clk = ~clk;

  lpc_mode_ctrl dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sharedClockPinIn(pinLevel), .sharedClockPinOut(pinOut),
    .sharedClockPinOe(pinOe), .pwmEnable(pwmEnable), .chanMode(chanMode),
    .pwmLevel(pwmLevel), .lineStrobe(lineStrobe),
    .frameStrobe(frameStrobe), .oscRunning(oscRunning),
    .lcdClkTick(lcdClkTick), .pwmClkTick(pwmClkTick),
    .lcdDriveEnable(lcdDriveEnable), .drivePolarity(drivePolarity),
    .gpOut(gpOut));

  lpc_pin_partner partner (.clk(clk), .pinOe(pinOe), .pinOut(pinOut),
    .runClk(runClk), .pinLevel(pinLevel));

  // ==========================================================
  // shared tasks
  task finish_test();
    $display("Mismatches %0d, comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: %s got %0h want %0h", $time, m, got, exp);
    end
  endtask

  // one transfer; the leading edge keeps back-to-back calls apart
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      bad_count++;
      $display("Error at %0t: no ready from slave", $time);
    end
    rdVal = prdata;
    errVal = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // command write, then let derived outputs settle
  task cmd(input logic [7:0] b);
    apb(1'b1, 8'h00, {24'h000000, b});
    repeat (3) @(posedge clk);
  endtask

  task count_ticks(input int n);
    ticks = 0;
    pwmTicks = 0;
    repeat (n)
    begin
      @(posedge clk);
      if (lcdClkTick === 1'b1)
        ticks++;
      if (pwmClkTick === 1'b1)
        pwmTicks++;
    end
  endtask

  task strobe(input logic isFrame, input logic flips);
    logic was;
    was = drivePolarity;
    lineStrobe <= !isFrame;
    frameStrobe <= isFrame;
    @(posedge clk);
    lineStrobe <= 1'b0;
    frameStrobe <= 1'b0;
    repeat (3) @(posedge clk);
    chk(drivePolarity, was ^ flips, "polarity");
  endtask

  // ==========================================================
  // scenarios
  task t_reset();
    apb(1'b0, 8'h04, 32'h0);
    chk(rdVal, 32'h0, "mode after reset");
    chk(oscRunning, 1'b1, "osc after reset");
    chk(pinOe, 1'b0, "pin tristate");
    chk(lcdDriveEnable, 1'b0, "display off");
    apb(1'b0, 8'h0C, 32'h0);
    chk({errVal, rdVal[30:0]}, 32'h80000000, "unmapped read");
  endtask

  task t_display();
    cmd(8'h51);
    chk(lcdDriveEnable, 1'b1, "display on");
    chk(gpOut, 6'h02, "gp with display on");
    cmd(8'h50);
    chk(lcdDriveEnable, 1'b0, "display off");
    chk(gpOut, 6'h02, "gp with display off");
  endtask

  task t_inversion();
    strobe(1'b0, 1'b1);
    strobe(1'b1, 1'b0);
    cmd(8'h54);
    strobe(1'b0, 1'b0);
    strobe(1'b1, 1'b1);
    cmd(8'h50);
  endtask

  task t_sleep();
    cmd(8'h1A);
    chk(pinOe, 1'b1, "clock out enabled");
    // static ch0 high, ch1 low so the pwm fallback is visible
    cmd(8'h61);
    chk(gpOut, 6'h03, "static and pwm awake");
    cmd(8'h51);
    cmd(8'h50); // display off before sleep
    cmd(8'h52);
    chk(oscRunning, 1'b0, "osc in sleep");
    chk(lcdDriveEnable, 1'b0, "outputs low in sleep");
    chk(gpOut, 6'h01, "pwm falls back to static");
    chk({pinOe, pinOut}, 2'h3, "pin high in sleep");
    cmd(8'h50);
    chk(oscRunning, 1'b1, "osc after wake");
    chk(gpOut, 6'h03, "pwm after wake");
  endtask

  task t_internal();
    cmd(8'h13);
    apb(1'b0, 8'h04, 32'h0);
    chk(rdVal, 32'h110, "foreign byte ignored");
    count_ticks(1736);
    chk(ticks, 2, "internal tick count");
    chk(pwmTicks, 2, "internal pwm tick count");
  endtask

  task t_external();
    runClk <= 1'b1;
    cmd(8'h1F);
    chk(pinOe, 1'b0, "clock out ignored");
    chk(oscRunning, 1'b0, "osc off on external");
    count_ticks(64);
    chk(ticks, 8, "external tick count");
    chk(pwmTicks, 8, "pwm on fast external");
    pwmEnable <= 1'b1;
    repeat (3) @(posedge clk);
    chk(oscRunning, 1'b0, "osc off at fast rate");
    cmd(8'h1B);
    chk(oscRunning, 1'b1, "osc for pwm at slow rate");
    count_ticks(1736);
    chk(ticks, 217, "slow external tick count");
    chk(pwmTicks, 2, "pwm from oscillator");
    runClk <= 1'b0;
    cmd(8'h52);
    count_ticks(64);
    chk(ticks, 0, "floating pin in sleep");
    chk(oscRunning, 1'b0, "osc stopped in sleep");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    runClk = 1'b0;
    pwmEnable = 1'b0;
    chanMode = 12'h00E;
    pwmLevel = 6'h3F;
    lineStrobe = 1'b0;
    frameStrobe = 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_display();
    t_inversion();
    t_sleep();
    t_internal();
    t_external();
    finish_test();
  end

  initial
  begin
    #100000;
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
